//--- hdl/ippe_pkg.sv
// Package with register map, field layout and event codes of the I/O ring port event generator.
package ippe_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_CTL0 = 4'h0;
    localparam logic [3:0] OFF_CTL1 = 4'h4;
    localparam logic [3:0] OFF_FILTER = 4'h8;
    localparam logic [3:0] OFF_STATUS = 4'hc;
    localparam logic [31:0] RST_CTL = 32'h0000_0000;
    localparam logic [4:0] RST_FILTER = 5'h00;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int EVSEL_LSB = 0;
    localparam int UMASK_LSB = 8;
    localparam int EN_BIT = 22;
    localparam int QSEL_W = 5;
    localparam int STAT_REQ_STALL = 8;
    localparam int STAT_DATA_STALL = 9;
    localparam int STAT_WORD_STALL = 10;
    localparam int INC_W = 6;
    localparam int NUM_CTR = 2;

    // ------------------------------------------------------------
    // Event codes and unit-mask bits
    // ------------------------------------------------------------
    localparam logic [7:0] EV_TICKLE = 8'h16;
    localparam logic [7:0] EV_TXN = 8'h15;
    localparam logic [7:0] EV_REQ_STALL = 8'h18;
    localparam logic [7:0] EV_DATA_STALL = 8'h19;
    localparam logic [7:0] EV_BYPASS_INS = 8'h0e;
    localparam logic [7:0] EV_STD_INS = 8'h0f;
    localparam logic [7:0] EV_OUT_FILL = 8'h0d;
    localparam logic [7:0] EV_WORD_STALL = 8'h1a;
    localparam int UM_LOST = 0;
    localparam int UM_HEAD = 1;
    localparam int UM_READ = 0;
    localparam int UM_WRITE = 1;
    localparam int UM_PREFETCH = 2;
    localparam int UM_SOURCE = 3;

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ippe_pkg

//--- hdl/ippe_event_gen.sv
// Event generator for the performance monitor of an I/O ring port, with an AXI4-Lite register slave.
//
// What this block does
// RULE_01 - Tickle event counts every tickle, explicit or from an internal conflict.
// RULE_02 - Lost-ownership mask counts the hit request plus every request queued behind it.
// RULE_03 - Head mask counts tickles hitting the queue head, where data returns.
// RULE_04 - Transaction event counts inbound transactions, qualified by type and optionally source.
// RULE_05 - Selected type matches are ORed, then ANDed with the source match if selected.
// RULE_06 - Mask bit 0 selects reads without prefetches; bit 2 selects read prefetches.
// RULE_07 - Mask bit 1 selects writes; every retry of a tickled write counts again.
// RULE_08 - Mask bit 3 restricts to one five-bit source queue; clear means all sources.
// RULE_09 - Count cycles a ring request waits for lack of a request credit.
// RULE_10 - Count cycles ring data waits for lack of a data credit.
// RULE_11 - Two outbound insert events, one per non-coherent message class.
// RULE_12 - Outbound fill event adds the outstanding outbound request count every cycle.
// RULE_13 - Count cycles with write acks pending while the switch-to-port pipe idles.
// RULE_14 - Each event other than tickle and outbound fill at most one per cycle, and only on counters 0 and 1.
// RULE_15 - Source qualification uses the single queue held in the filter register.
// RULE_16 - Increment only with matching event code and true mask qualification.
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps

module ippe_event_gen (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Tickles
    input wire logic tickle_valid,
    input wire logic tickle_at_head,
    input wire logic [4:0] tickle_lost_count,
    // Inbound transactions
    input wire logic txn_valid,
    input wire logic txn_is_read,
    input wire logic txn_is_write,
    input wire logic txn_is_prefetch,
    input wire logic [4:0] txn_src_queue,
    // Ring egress credits
    input wire logic ring_req_pending,
    input wire logic ring_req_credit,
    input wire logic ring_data_pending,
    input wire logic ring_data_credit,
    // Outbound requests and ordering
    input wire logic out_bypass_insert,
    input wire logic out_standard_insert,
    input wire logic [5:0] out_outstanding,
    input wire logic wr_ack_pending,
    input wire logic switch_pipe_busy,
    // Increments toward generic counters 0 and 1
    output logic [5:0] ctr0_inc,
    output logic [5:0] ctr1_inc
);

    logic [31:0] ctl [ippe_pkg::NUM_CTR];
    logic [ippe_pkg::QSEL_W-1:0] source_queue_select;
    logic [3:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic do_write;
    logic next_aw_held;
    logic next_w_held;
    logic [31:0] status_word;
    logic [ippe_pkg::INC_W-1:0] next_inc [ippe_pkg::NUM_CTR];

    // ------------------------------------------------------------
    // Event evaluation
    // ------------------------------------------------------------
    // Shared by both counters so their decode can never disagree.
    function automatic logic [5:0] ippe_eval(input logic [31:0] cfg, input logic [4:0] qsel);
        logic [7:0] code;
        logic [7:0] um;
        logic type_hit;
        logic [5:0] amt;
        code = cfg[ippe_pkg::EVSEL_LSB +: 8];
        um = cfg[ippe_pkg::UMASK_LSB +: 8];
        type_hit = 1'b0;
        amt = 6'h00;
        if (!cfg[ippe_pkg::EN_BIT]) begin
            amt = 6'h00; // [RULE_16]
        end else if (code == ippe_pkg::EV_TICKLE) begin
            if (tickle_valid) begin
                if (um[ippe_pkg::UM_LOST] || um[ippe_pkg::UM_HEAD]) begin
                    if (um[ippe_pkg::UM_LOST] && !tickle_at_head) begin
                        amt = {1'b0, tickle_lost_count}; // [RULE_02]
                    end
                    if (um[ippe_pkg::UM_HEAD] && tickle_at_head) begin
                        amt = 6'h01; // [RULE_03]
                    end
                end else begin
                    amt = 6'h01; // [RULE_01]
                end
            end
        end else if (code == ippe_pkg::EV_TXN) begin
            // A retried write arrives as a fresh txn_valid and so counts again.
            type_hit = (um[ippe_pkg::UM_READ] && txn_is_read && !txn_is_prefetch) // [RULE_06]
                || (um[ippe_pkg::UM_WRITE] && txn_is_write) // [RULE_07]
                || (um[ippe_pkg::UM_PREFETCH] && txn_is_prefetch); // [RULE_05]
            if (um[ippe_pkg::UM_SOURCE] && txn_src_queue != qsel) begin
                type_hit = 1'b0; // [RULE_08] [RULE_15]
            end
            amt = {5'h00, txn_valid && type_hit}; // [RULE_04]
        end else if (code == ippe_pkg::EV_REQ_STALL) begin
            amt = {5'h00, ring_req_pending && !ring_req_credit}; // [RULE_09]
        end else if (code == ippe_pkg::EV_DATA_STALL) begin
            amt = {5'h00, ring_data_pending && !ring_data_credit}; // [RULE_10]
        end else if (code == ippe_pkg::EV_BYPASS_INS) begin
            amt = {5'h00, out_bypass_insert}; // [RULE_11]
        end else if (code == ippe_pkg::EV_STD_INS) begin
            amt = {5'h00, out_standard_insert}; // [RULE_11]
        end else if (code == ippe_pkg::EV_OUT_FILL) begin
            amt = out_outstanding; // [RULE_12]
        end else if (code == ippe_pkg::EV_WORD_STALL) begin
            amt = {5'h00, wr_ack_pending && !switch_pipe_busy}; // [RULE_13]
        end
        return amt;
    endfunction : ippe_eval

    // ------------------------------------------------------------
    // Counter increments
    // ------------------------------------------------------------
    // Only two counter slots exist, so no other counter can see these events.
    for (genvar g = 0; g < ippe_pkg::NUM_CTR; g++) begin : g_inc
        always_comb begin
            next_inc[g] = ippe_eval(ctl[g], source_queue_select); // [RULE_14] [RULE_16]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctr0_inc <= 6'h00;
            ctr1_inc <= 6'h00;
        end else begin
            ctr0_inc <= next_inc[0];
            ctr1_inc <= next_inc[1];
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    // Either AW or W may be taken first.
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
        end else if (do_write) begin
            next_aw_held = 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
        end else if (do_write) begin
            next_w_held = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            s_axi_awready <= !next_aw_held;
            s_axi_wready <= !next_w_held;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ippe_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr == ippe_pkg::OFF_CTL0 || aw_addr == ippe_pkg::OFF_CTL1
                || aw_addr == ippe_pkg::OFF_FILTER || aw_addr == ippe_pkg::OFF_STATUS) begin
                s_axi_bresp <= ippe_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= ippe_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl[0] <= ippe_pkg::RST_CTL;
            ctl[1] <= ippe_pkg::RST_CTL;
            source_queue_select <= ippe_pkg::RST_FILTER;
        end else if (do_write) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb[b] && aw_addr == ippe_pkg::OFF_CTL0) begin
                    ctl[0][b*8 +: 8] <= w_data[b*8 +: 8];
                end else if (w_strb[b] && aw_addr == ippe_pkg::OFF_CTL1) begin
                    ctl[1][b*8 +: 8] <= w_data[b*8 +: 8];
                end
            end
            if (w_strb[0] && aw_addr == ippe_pkg::OFF_FILTER) begin
                source_queue_select <= w_data[ippe_pkg::QSEL_W-1:0]; // [RULE_15]
            end
        end
    end

    // Status is a live view, so a read shows the state of the cycle it was taken in.
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[5:0] = out_outstanding;
        status_word[ippe_pkg::STAT_REQ_STALL] = ring_req_pending && !ring_req_credit;
        status_word[ippe_pkg::STAT_DATA_STALL] = ring_data_pending && !ring_data_credit;
        status_word[ippe_pkg::STAT_WORD_STALL] = wr_ack_pending && !switch_pipe_busy;
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ippe_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= ippe_pkg::RESP_OKAY;
            if (s_axi_araddr == ippe_pkg::OFF_CTL0) begin
                s_axi_rdata <= ctl[0];
            end else if (s_axi_araddr == ippe_pkg::OFF_CTL1) begin
                s_axi_rdata <= ctl[1];
            end else if (s_axi_araddr == ippe_pkg::OFF_FILTER) begin
                s_axi_rdata <= {27'h0, source_queue_select};
            end else if (s_axi_araddr == ippe_pkg::OFF_STATUS) begin
                s_axi_rdata <= status_word;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= ippe_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Assertions on counter 0, cover points on both counters and the bus
    // ------------------------------------------------------------
    logic [31:0] cfg0;
    assign cfg0 = ctl[0];

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_tickle_plain: assert property ( // [RULE_01]
        $past(cfg0) == 32'h0040_0016 |-> ctr0_inc == {5'h00, $past(tickle_valid)})
        else $error("plain tickle count wrong");
    chk_lost_owner: assert property ( // [RULE_02]
        $past(cfg0) == 32'h0040_0116 && $past(tickle_valid) && !$past(tickle_at_head)
        |-> ctr0_inc == {1'b0, $past(tickle_lost_count)})
        else $error("lost ownership amount wrong");
    chk_head_return: assert property ( // [RULE_03]
        $past(cfg0) == 32'h0040_0216
        |-> ctr0_inc == {5'h00, $past(tickle_valid) && $past(tickle_at_head)})
        else $error("head tickle count wrong");
    chk_read_only: assert property ( // [RULE_06]
        $past(cfg0) == 32'h0040_0115
        |-> ctr0_inc == {5'h00, $past(txn_valid) && $past(txn_is_read) && !$past(txn_is_prefetch)})
        else $error("read qualification wrong");
    chk_source_miss: assert property ( // [RULE_08]
        $past(cfg0[ippe_pkg::EN_BIT]) && $past(cfg0[7:0]) == ippe_pkg::EV_TXN && $past(cfg0[11])
        && $past(txn_src_queue) != $past(source_queue_select) |-> ctr0_inc == 6'h00)
        else $error("source filter leaked");
    chk_req_stall: assert property ( // [RULE_09]
        $past(cfg0) == 32'h0040_0018 && $past(ring_req_pending) && !$past(ring_req_credit)
        |-> ctr0_inc == 6'h01)
        else $error("request stall missed");
    chk_data_stall: assert property ( // [RULE_10]
        $past(cfg0) == 32'h0040_0019 && $past(ring_data_credit) |-> ctr0_inc == 6'h00)
        else $error("data stall counted with credit");
    chk_fill_sum: assert property ( // [RULE_12]
        $past(cfg0) == 32'h0040_000d |-> ctr0_inc == $past(out_outstanding))
        else $error("occupancy amount wrong");
    chk_write_order: assert property ( // [RULE_13]
        $past(cfg0) == 32'h0040_001a
        |-> ctr0_inc == {5'h00, $past(wr_ack_pending) && !$past(switch_pipe_busy)})
        else $error("write ordering stall wrong");
    chk_off_silent: assert property ( // [RULE_16]
        !cfg0[ippe_pkg::EN_BIT] [*2] |-> ctr0_inc == 6'h00)
        else $error("disabled counter moved");
    chk_single_step: assert property ( // [RULE_14]
        $past(cfg0[7:0]) != ippe_pkg::EV_OUT_FILL && $past(cfg0[7:0]) != ippe_pkg::EV_TICKLE
        |-> ctr0_inc <= 6'h01)
        else $error("increment above one");
    chk_bypass_ins: assert property ( // [RULE_11]
        $past(cfg0) == 32'h0040_000e |-> ctr0_inc == {5'h00, $past(out_bypass_insert)})
        else $error("bypass insert count wrong");

    cov_lost_owner: cover property ($past(cfg0) == 32'h0040_0116 && ctr0_inc > 6'h01);
    cov_src_hit: cover property ($past(cfg0) == 32'h0040_0915 && ctr0_inc == 6'h01);
    cov_fill: cover property ($past(cfg0) == 32'h0040_000d && ctr0_inc > 6'h02);
    cov_bus_err: cover property (s_axi_rvalid && s_axi_rresp == ippe_pkg::RESP_SLVERR);
    cov_head_ret: cover property ($past(ctl[1]) == 32'h0040_0216 && ctr1_inc == 6'h01);

endmodule : ippe_event_gen

//--- verif/ippe_ctr_model.sv
// Behavioural model of the two generic counters that accumulate the increments.
`timescale 1ns/1ps

module ippe_ctr_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Increments from the event generator and a clear from software
    input wire logic [5:0] ctr0_inc,
    input wire logic [5:0] ctr1_inc,
    input wire logic clear,
    // Running totals
    output logic [31:0] total0,
    output logic [31:0] total1
);
    // Only two generic counters exist, so only two increment streams are summed.
    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            total0 <= 32'h0000_0000;
            total1 <= 32'h0000_0000;
        end else begin
            total0 <= total0 + {26'h0, ctr0_inc};
            total1 <= total1 + {26'h0, ctr1_inc};
        end
    end
endmodule : ippe_ctr_model

//--- verif/tb_top.sv
// Self-checking testbench for the I/O ring port event generator.
`timescale 1ns/1ps

module tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic aclk = 1'b0, aresetn = 1'b0, acc_clear = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, total0, total1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] ctr0_inc, ctr1_inc, out_outstanding = 6'h0;
    logic [4:0] tickle_lost_count = 5'h0, txn_src_queue = 5'h0;
    logic tickle_valid = 0, tickle_at_head = 0, txn_valid = 0, txn_is_read = 0, txn_is_write = 0, txn_is_prefetch = 0;
    logic ring_req_pending = 0, ring_req_credit = 0, ring_data_pending = 0, ring_data_credit = 0;
    logic out_bypass_insert = 0, out_standard_insert = 0, wr_ack_pending = 0, switch_pipe_busy = 0;
    int bad_count = 0, tests_run = 0, cycles = 0;

    ippe_event_gen u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tickle_valid,
        .tickle_at_head, .tickle_lost_count, .txn_valid, .txn_is_read, .txn_is_write, .txn_is_prefetch,
        .txn_src_queue, .ring_req_pending, .ring_req_credit, .ring_data_pending, .ring_data_credit,
        .out_bypass_insert, .out_standard_insert, .out_outstanding, .wr_ack_pending, .switch_pipe_busy,
        .ctr0_inc, .ctr1_inc);
    ippe_ctr_model u_ctr (.aclk, .aresetn, .ctr0_inc, .ctr1_inc, .clear(acc_clear), .total0, .total1);

    initial begin
        forever #5 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic got = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                got = 1'b1;
                s_axi_bready <= 1'b0;
                check("write response", {30'h0, s_axi_bresp}, {30'h0, er});
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic got = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                got = 1'b1;
                s_axi_rready <= 1'b0;
                check("read data", s_axi_rdata, ed);
                check("read response", {30'h0, s_axi_rresp}, {30'h0, er});
            end
        end
    endtask : axi_rd

    task automatic set_ctl(input logic n, input logic [7:0] code, input logic [7:0] um, input logic en);
        axi_wr(n ? ippe_pkg::OFF_CTL1 : ippe_pkg::OFF_CTL0, {9'h0, en, 6'h0, um, code}, ippe_pkg::RESP_OKAY);
    endtask : set_ctl

    task automatic idle();
        {tickle_valid, tickle_at_head, tickle_lost_count, txn_valid, txn_is_read, txn_is_write, txn_is_prefetch,
            txn_src_queue, ring_req_pending, ring_req_credit, ring_data_pending, ring_data_credit,
            out_bypass_insert, out_standard_insert, out_outstanding, wr_ack_pending, switch_pipe_busy} <= '0;
    endtask : idle

    // Increments are flip-flops, so they show one edge after the inputs are taken.
    task automatic sample(input logic [5:0] e0, input logic [5:0] e1, input logic keep);
        @(posedge aclk);
        if (!keep) idle();
        #1;
        check("counter 0 increment", {26'h0, ctr0_inc}, {26'h0, e0});
        check("counter 1 increment", {26'h0, ctr1_inc}, {26'h0, e1});
    endtask : sample

    task automatic tkl(input logic h, input logic [4:0] n);
        @(posedge aclk);
        tickle_valid <= 1'b1;
        tickle_at_head <= h;
        tickle_lost_count <= n;
    endtask : tkl

    task automatic txn(input logic rd, input logic wr, input logic pf, input logic [4:0] src);
        @(posedge aclk);
        {txn_valid, txn_is_read, txn_is_write, txn_is_prefetch, txn_src_queue} <= {1'b1, rd, wr, pf, src};
    endtask : txn

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        axi_rd(ippe_pkg::OFF_CTL0, ippe_pkg::RST_CTL, ippe_pkg::RESP_OKAY);
        axi_rd(ippe_pkg::OFF_CTL1, ippe_pkg::RST_CTL, ippe_pkg::RESP_OKAY);
        axi_rd(ippe_pkg::OFF_FILTER, 32'h0, ippe_pkg::RESP_OKAY);
        axi_wr(ippe_pkg::OFF_CTL1, 32'hffff_ffff, ippe_pkg::RESP_OKAY);
        axi_rd(ippe_pkg::OFF_CTL1, 32'hffff_ffff, ippe_pkg::RESP_OKAY);
        axi_wr(ippe_pkg::OFF_CTL1, 32'h0, ippe_pkg::RESP_OKAY);
        axi_wr(ippe_pkg::OFF_FILTER, 32'hffff_ffff, ippe_pkg::RESP_OKAY);
        axi_rd(ippe_pkg::OFF_FILTER, 32'h0000_001f, ippe_pkg::RESP_OKAY);
        axi_wr(ippe_pkg::OFF_STATUS, 32'hffff_ffff, ippe_pkg::RESP_OKAY);
        axi_rd(ippe_pkg::OFF_STATUS, 32'h0, ippe_pkg::RESP_OKAY);
        axi_wr(4'h2, 32'h1, ippe_pkg::RESP_SLVERR);
        axi_rd(4'h2, 32'h0, ippe_pkg::RESP_SLVERR);
        $display("test regs finished");
    endtask : t_regs

    task automatic t_tickle();
        set_ctl(1'b0, ippe_pkg::EV_TICKLE, 8'h01, 1'b1);
        set_ctl(1'b1, ippe_pkg::EV_TICKLE, 8'h02, 1'b1);
        tkl(1'b0, 5'h05);
        sample(6'h05, 6'h00, 1'b0);
        tkl(1'b1, 5'h01);
        sample(6'h00, 6'h01, 1'b0);
        tkl(1'b0, 5'h1f);
        sample(6'h1f, 6'h00, 1'b0);
        sample(6'h00, 6'h00, 1'b0);
        set_ctl(1'b0, ippe_pkg::EV_TICKLE, 8'h00, 1'b1);
        tkl(1'b1, 5'h03);
        sample(6'h01, 6'h01, 1'b0);
        tkl(1'b0, 5'h03);
        sample(6'h01, 6'h00, 1'b0);
        $display("test tickle finished");
    endtask : t_tickle

    task automatic t_txn();
        set_ctl(1'b0, ippe_pkg::EV_TXN, 8'h01, 1'b1);
        set_ctl(1'b1, ippe_pkg::EV_TXN, 8'h04, 1'b1);
        txn(1'b1, 1'b0, 1'b0, 5'h03);
        sample(6'h01, 6'h00, 1'b0);
        txn(1'b1, 1'b0, 1'b1, 5'h03);
        sample(6'h00, 6'h01, 1'b0);
        txn(1'b0, 1'b0, 1'b1, 5'h03);
        sample(6'h00, 6'h01, 1'b0);
        txn(1'b0, 1'b1, 1'b0, 5'h03);
        sample(6'h00, 6'h00, 1'b0);
        axi_wr(ippe_pkg::OFF_FILTER, 32'h0000_0013, ippe_pkg::RESP_OKAY);
        set_ctl(1'b0, ippe_pkg::EV_TXN, 8'h0b, 1'b1);
        set_ctl(1'b1, ippe_pkg::EV_TXN, 8'h02, 1'b1);
        txn(1'b0, 1'b1, 1'b0, 5'h13);
        sample(6'h01, 6'h01, 1'b1);
        sample(6'h01, 6'h01, 1'b0);
        txn(1'b1, 1'b0, 1'b0, 5'h13);
        sample(6'h01, 6'h00, 1'b0);
        txn(1'b0, 1'b1, 1'b0, 5'h12);
        sample(6'h00, 6'h01, 1'b0);
        $display("test transactions finished");
    endtask : t_txn

    // A disabled counter 1 on the same code must stay silent.
    task automatic t_stall();
        logic [7:0] codes [5] = '{ippe_pkg::EV_REQ_STALL, ippe_pkg::EV_DATA_STALL, ippe_pkg::EV_WORD_STALL,
            ippe_pkg::EV_BYPASS_INS, ippe_pkg::EV_STD_INS};
        for (int i = 0; i < 5; i++) begin
            set_ctl(1'b0, codes[i], 8'h00, 1'b1);
            set_ctl(1'b1, codes[i], 8'h00, 1'b0);
            for (int p = 0; p < 2; p++) begin
                @(posedge aclk);
                case (i)
                    0: {ring_req_pending, ring_req_credit} <= {1'b1, p == 0};
                    1: {ring_data_pending, ring_data_credit} <= {1'b1, p == 0};
                    2: {wr_ack_pending, switch_pipe_busy} <= {1'b1, p == 0};
                    3: out_bypass_insert <= (p == 1);
                    default: out_standard_insert <= (p == 1);
                endcase
                sample({5'h0, p == 1}, 6'h00, 1'b0);
            end
        end
        @(posedge aclk);
        {ring_req_pending, ring_data_pending, wr_ack_pending} <= 3'b111;
        out_outstanding <= 6'h05;
        axi_rd(ippe_pkg::OFF_STATUS, 32'h0000_0705, ippe_pkg::RESP_OKAY);
        sample(6'h00, 6'h00, 1'b0);
        $display("test stalls finished");
    endtask : t_stall

    task automatic t_occ();
        set_ctl(1'b0, ippe_pkg::EV_OUT_FILL, 8'h00, 1'b1);
        set_ctl(1'b1, ippe_pkg::EV_BYPASS_INS, 8'h00, 1'b1);
        @(posedge aclk);
        acc_clear <= 1'b1;
        @(posedge aclk);
        acc_clear <= 1'b0;
        out_outstanding <= 6'h25;
        out_bypass_insert <= 1'b1;
        repeat (10) @(posedge aclk);
        idle();
        repeat (3) @(posedge aclk);
        #1;
        check("fill total", total0, 32'd370);
        check("insert total", total1, 32'd10);
        $display("test occupancy finished");
    endtask : t_occ

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_sim();
        end
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs();
        t_tickle();
        t_txn();
        t_stall();
        t_occ();
        end_sim();
    end
endmodule : tb_top
